// >>> bt1h_cfg.svh
// Constants for the bridge header lower register bank (offsets 0Ch to 1Ch).
// Assumes inclusion by bare name from the bridge header module.
`ifndef BT1H_CFG_SVH
`define BT1H_CFG_SVH

`define BT1H_OFS_MISC 8'h0c
`define BT1H_OFS_WIN_LO 8'h10
`define BT1H_OFS_WIN_HI 8'h14
`define BT1H_OFS_BUS 8'h18
`define BT1H_OFS_IO 8'h1c

`define BT1H_CLS_RST 8'h00
`define BT1H_LAYOUT_TYPE 7'h01
`define BT1H_MULTI_FN 1'h0
`define BT1H_CONFIG_WINDOW_BASE_LOW_LSB 18
`define BT1H_CONFIG_WINDOW_BASE_LOW_RST 14'h0000
`define BT1H_CONFIG_WINDOW_BASE_HIGH_RST 32'h0000_0000
`define BT1H_MAP_RST 2'h0
`define BT1H_BUS_RST 8'h00
`define BT1H_IO_CAP 4'h1
`define BT1H_IOBASE_RST 4'hf
`define BT1H_IOLIM_RST 4'h0
`define BT1H_IO_BASE_LOW 12'h000
`define BT1H_IO_LIM_LOW 12'hfff
`define BT1H_PERR_BIT 24
`define BT1H_ZERO_BYTE 8'h00
`define BT1H_ZERO_WORD 32'h0000_0000

`endif

// >>> bt1h_pkg.sv
// Types shared by the bridge header lower register bank.
// Assumes the constants header sits in the same folder.
package bt1h_pkg;
	typedef logic [31:0] bt1h_word_t;
	typedef logic [1:0] bt1h_map_t;
	localparam bt1h_map_t BT1H_MAP_32 = 2'h0;
	localparam bt1h_map_t BT1H_MAP_64 = 2'h2;
endpackage

// >>> bt1h_io_window.sv
// Combinational I/O window compare for one port.
// Assumes base and limit words are already assembled by the caller.
`timescale 1ns/1ps
module bt1h_io_window (
	input wire logic [31:0] base,
	input wire logic [31:0] limit,
	input wire logic [31:0] addr,
	output logic window_open,
	output logic in_window
);
	// A closed window (limit below base) matches nothing.
	assign window_open = (base <= limit);
	assign in_window = window_open && (addr >= base) && (addr <= limit);
endmodule

// >>> bt1h_sticky_bit.sv
// One sticky status bit, set by hardware, cleared by writing one.
// Assumes set, clear and load come from logic on the same clock.
`timescale 1ns/1ps
module bt1h_sticky_bit (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic set,
	input wire logic clr,
	input wire logic load,
	input wire logic load_val,
	output logic q
);
	logic q_next;
	// A set in the same cycle as a clear wins, so no event is lost.
	assign q_next = set ? 1'b1 : (load ? load_val : (clr ? 1'b0 : q));
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= 1'b0;
		end else if (ce) begin
			q <= q_next;
		end
	end
endmodule

// >>> bt1h_bridge_hdr.sv
// Bridge header lower register bank: offsets 0Ch to 1Ch, I/O forwarding decision.
// Assumes configuration accesses, nonvolatile preset and request inputs share core_clk;
// the port role strap comes from a pin and is synchronised here.
`timescale 1ns/1ps
`include "bt1h_cfg.svh"
module bt1h_bridge_hdr (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic port_is_upstream,
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_valid,
	input wire logic nv_wr_en,
	input wire logic [7:0] nv_addr,
	input wire logic [31:0] nv_wdata,
	input wire logic perr_resp_en,
	input wire logic poison_cpl_rx,
	input wire logic poison_wr_fwd,
	output logic poison_record,
	input wire logic [15:0] io_base_upper,
	input wire logic [15:0] io_limit_upper,
	input wire logic io_req_valid,
	input wire logic io_req_from_secondary,
	input wire logic [31:0] io_req_addr,
	output logic io_fwd_valid,
	output logic io_fwd_down,
	output logic io_fwd_up,
	output logic [7:0] secondary_bus,
	output logic [7:0] subordinate_bus
);
	logic up_meta_reg;
	logic up_sync_reg;
	logic [7:0] cache_line_reg;
	bt1h_pkg::bt1h_map_t map_type_reg;
	logic [13:0] config_window_base_low_base_reg;
	logic [31:0] config_window_base_high_reg;
	logic [7:0] bus_num_reg [3];
	logic [3:0] io_base_nib_reg;
	logic [3:0] io_lim_nib_reg;
	logic perr_status;
	logic [7:0] rd_addr_reg;

	// Port role strap: two flip-flops, only the second is read.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			up_meta_reg <= 1'b0;
			up_sync_reg <= 1'b0;
		end else if (ce) begin
			up_meta_reg <= port_is_upstream;
			up_sync_reg <= up_meta_reg;
		end
	end

	wire wr_misc = cfg_wr_en && (cfg_addr == `BT1H_OFS_MISC);
	wire wr_win_lo = cfg_wr_en && (cfg_addr == `BT1H_OFS_WIN_LO) && up_sync_reg;
	wire wr_win_hi = cfg_wr_en && (cfg_addr == `BT1H_OFS_WIN_HI) && up_sync_reg;
	wire wr_bus = cfg_wr_en && (cfg_addr == `BT1H_OFS_BUS);
	wire wr_io = cfg_wr_en && (cfg_addr == `BT1H_OFS_IO);
	wire nv_misc = nv_wr_en && (nv_addr == `BT1H_OFS_MISC);
	wire nv_win_lo = nv_wr_en && (nv_addr == `BT1H_OFS_WIN_LO) && up_sync_reg;
	wire nv_win_hi = nv_wr_en && (nv_addr == `BT1H_OFS_WIN_HI) && up_sync_reg;
	wire nv_bus = nv_wr_en && (nv_addr == `BT1H_OFS_BUS);
	wire nv_io = nv_wr_en && (nv_addr == `BT1H_OFS_IO);
	wire win_is_64 = (map_type_reg == bt1h_pkg::BT1H_MAP_64);

	// Nonvolatile preset takes priority over a software write in the same cycle.
	wire [7:0] cache_line_next = nv_misc ? nv_wdata[7:0] :
		((wr_misc && cfg_be[0]) ? cfg_wdata[7:0] : cache_line_reg);
	// Map type is read-only to software; only the preset may change it.
	wire [1:0] map_type_next = nv_win_lo ? nv_wdata[2:1] : map_type_reg;
	wire [13:0] config_window_base_low_wr_val = {cfg_be[3] ? cfg_wdata[31:24] : config_window_base_low_base_reg[13:6],
		cfg_be[2] ? cfg_wdata[23:18] : config_window_base_low_base_reg[5:0]};
	wire [13:0] config_window_base_low_base_next = nv_win_lo ? nv_wdata[31:`BT1H_CONFIG_WINDOW_BASE_LOW_LSB] :
		(wr_win_lo ? config_window_base_low_wr_val : config_window_base_low_base_reg);
	wire [31:0] config_window_base_high_wr_val = {cfg_be[3] ? cfg_wdata[31:24] : config_window_base_high_reg[31:24],
		cfg_be[2] ? cfg_wdata[23:16] : config_window_base_high_reg[23:16],
		cfg_be[1] ? cfg_wdata[15:8] : config_window_base_high_reg[15:8],
		cfg_be[0] ? cfg_wdata[7:0] : config_window_base_high_reg[7:0]};
	wire [31:0] config_window_base_high_next = (nv_win_hi && win_is_64) ? nv_wdata :
		((wr_win_hi && win_is_64) ? config_window_base_high_wr_val : config_window_base_high_reg);
	wire [3:0] io_base_nib_next = nv_io ? nv_wdata[7:4] :
		((wr_io && cfg_be[0]) ? cfg_wdata[7:4] : io_base_nib_reg);
	wire [3:0] io_lim_nib_next = nv_io ? nv_wdata[15:12] :
		((wr_io && cfg_be[1]) ? cfg_wdata[15:12] : io_lim_nib_reg);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cache_line_reg <= `BT1H_CLS_RST;
			map_type_reg <= `BT1H_MAP_RST;
			config_window_base_low_base_reg <= `BT1H_CONFIG_WINDOW_BASE_LOW_RST;
			config_window_base_high_reg <= `BT1H_CONFIG_WINDOW_BASE_HIGH_RST;
			io_base_nib_reg <= `BT1H_IOBASE_RST;
			io_lim_nib_reg <= `BT1H_IOLIM_RST;
		end else if (ce) begin
			cache_line_reg <= cache_line_next;
			map_type_reg <= map_type_next;
			config_window_base_low_base_reg <= config_window_base_low_base_next;
			config_window_base_high_reg <= config_window_base_high_next;
			io_base_nib_reg <= io_base_nib_next;
			io_lim_nib_reg <= io_lim_nib_next;
		end
	end

	// Primary, secondary and subordinate bus bytes, one lane each.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_bus
			wire [7:0] bus_next = nv_bus ? nv_wdata[g*8 +: 8] :
				((wr_bus && cfg_be[g]) ? cfg_wdata[g*8 +: 8] : bus_num_reg[g]);
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					bus_num_reg[g] <= `BT1H_BUS_RST;
				end else if (ce) begin
					bus_num_reg[g] <= bus_next;
				end
			end
		end
	endgenerate

	// Poison events set the parity status only while the response enable is on.
	wire poison_event = poison_cpl_rx || poison_wr_fwd;
	wire perr_set = perr_resp_en && poison_event;
	wire perr_clr = wr_io && cfg_be[3] && cfg_wdata[`BT1H_PERR_BIT];

	bt1h_sticky_bit u_perr (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.ce(ce),
		.set(perr_set),
		.clr(perr_clr),
		.load(nv_io),
		.load_val(nv_wdata[`BT1H_PERR_BIT]),
		.q(perr_status)
	);

	// Read words; reserved and unsupported fields are tied to zero.
	wire [31:0] rd_misc = {`BT1H_ZERO_BYTE, `BT1H_MULTI_FN, `BT1H_LAYOUT_TYPE,
		`BT1H_ZERO_BYTE, cache_line_reg};
	// Space indicator and prefetchable bits stay zero; downstream the word is reserved.
	wire [31:0] rd_win_lo = up_sync_reg ?
		{config_window_base_low_base_reg, 14'h0000, 1'b0, map_type_reg, 1'b0} : `BT1H_ZERO_WORD;
	wire [31:0] rd_win_hi = (up_sync_reg && win_is_64) ? config_window_base_high_reg : `BT1H_ZERO_WORD;
	wire [31:0] rd_bus = {`BT1H_ZERO_BYTE, bus_num_reg[2], bus_num_reg[1], bus_num_reg[0]};
	wire [31:0] rd_io = {7'h00, perr_status, 8'h00, io_lim_nib_reg, `BT1H_IO_CAP,
		io_base_nib_reg, `BT1H_IO_CAP};
	wire [31:0] rd_sel = (cfg_addr == `BT1H_OFS_MISC) ? rd_misc :
		(cfg_addr == `BT1H_OFS_WIN_LO) ? rd_win_lo :
		(cfg_addr == `BT1H_OFS_WIN_HI) ? rd_win_hi :
		(cfg_addr == `BT1H_OFS_BUS) ? rd_bus :
		(cfg_addr == `BT1H_OFS_IO) ? rd_io : `BT1H_ZERO_WORD;

	// I/O window: upper halves come from the external upper-bits register.
	wire [31:0] io_base = {io_base_upper, io_base_nib_reg, `BT1H_IO_BASE_LOW};
	wire [31:0] io_limit = {io_limit_upper, io_lim_nib_reg, `BT1H_IO_LIM_LOW};
	logic win_open;
	logic win_hit;

	bt1h_io_window u_win (
		.base(io_base),
		.limit(io_limit),
		.addr(io_req_addr),
		.window_open(win_open),
		.in_window(win_hit)
	);

	wire fwd_down_next = io_req_valid && !io_req_from_secondary && win_hit;
	wire fwd_up_next = io_req_valid && io_req_from_secondary && !win_hit;

	// Every output comes from a flip-flop; reads answer one cycle after the strobe.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_rdata <= `BT1H_ZERO_WORD;
			cfg_rd_valid <= 1'b0;
			rd_addr_reg <= `BT1H_ZERO_BYTE;
			poison_record <= 1'b0;
			io_fwd_valid <= 1'b0;
			io_fwd_down <= 1'b0;
			io_fwd_up <= 1'b0;
			secondary_bus <= `BT1H_BUS_RST;
			subordinate_bus <= `BT1H_BUS_RST;
		end else if (ce) begin
			cfg_rdata <= cfg_rd_en ? rd_sel : `BT1H_ZERO_WORD;
			cfg_rd_valid <= cfg_rd_en;
			rd_addr_reg <= cfg_addr;
			poison_record <= poison_event;
			io_fwd_valid <= io_req_valid;
			io_fwd_down <= fwd_down_next;
			io_fwd_up <= fwd_up_next;
			secondary_bus <= bus_num_reg[1];
			subordinate_bus <= bus_num_reg[2];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_cls_write: assert property (ce && wr_misc && cfg_be[0] && !nv_wr_en
		|=> cache_line_reg == $past(cfg_wdata[7:0]))
		else $error("cache line size write not stored");
	a_misc_fixed: assert property (cfg_rd_valid && rd_addr_reg == `BT1H_OFS_MISC
		|-> cfg_rdata[31:8] == 24'h00_01_00)
		else $error("misc word fixed fields wrong");
	a_layout_type: assert property (cfg_rd_valid && rd_addr_reg == `BT1H_OFS_MISC
		|-> cfg_rdata[22:16] == 7'h01 && !cfg_rdata[23])
		else $error("layout type or multi-function wrong");
	a_win_lo_zero: assert property (cfg_rd_valid && rd_addr_reg == `BT1H_OFS_WIN_LO
		|-> cfg_rdata[17:3] == 15'h0000 && !cfg_rdata[0])
		else $error("window base low bits not zero");
	a_win_hi_gate: assert property (ce && cfg_rd_en && cfg_addr == `BT1H_OFS_WIN_HI
		&& !win_is_64 |=> cfg_rdata == 32'h0000_0000)
		else $error("upper window word not zero in 32-bit mode");
	a_win_hi_hold: assert property (ce && wr_win_hi && !win_is_64 && !nv_wr_en
		|=> $stable(config_window_base_high_reg))
		else $error("upper window word written in 32-bit mode");
	a_bus_write: assert property (ce && wr_bus && cfg_be[1] && !nv_wr_en
		|=> ##1 secondary_bus == $past(cfg_wdata[15:8], 2))
		else $error("secondary bus byte not written");
	a_io_caps: assert property (cfg_rd_valid && rd_addr_reg == `BT1H_OFS_IO
		|-> cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1
		&& cfg_rdata[23:16] == 8'h00 && cfg_rdata[31:25] == 7'h00)
		else $error("I/O capability or status zero fields wrong");
	a_fwd_down: assert property (ce && io_req_valid && !io_req_from_secondary
		|=> io_fwd_down == ($past(io_req_addr) >= $past(io_base)
		&& $past(io_req_addr) <= $past(io_limit)))
		else $error("downstream forward decision wrong");
	a_closed_win: assert property (ce && io_req_valid && !win_open
		|=> !io_fwd_down && (io_fwd_up == $past(io_req_from_secondary)))
		else $error("closed window forwarding wrong");
	a_perr_gate: assert property (!perr_status ##1 perr_status && !$past(nv_wr_en)
		|-> $past(perr_resp_en) && $past(poison_event))
		else $error("parity status set without enable");
	// A set must land even when a clear arrives in the same cycle; a later clear may drop it.
	a_perr_set: assert property (ce && perr_set |=> perr_status)
		else $error("parity status not set after event");
endmodule

// >>> bt1h_host_model.sv
// Host configuration software model: issues register reads and writes.
// Assumes the bank samples strobes on core_clk and answers a read one cycle later.
`timescale 1ns/1ps
module bt1h_host_model (
	input wire logic core_clk,
	output logic cfg_wr_en,
	output logic cfg_rd_en,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rd_valid
);
	initial begin
		cfg_wr_en = 1'b0;
		cfg_rd_en = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// Write data is inverted once released so a stale value is never mistaken for a fresh one.
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge core_clk);
		#1;
		cfg_wr_en = 1'b1;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		@(posedge core_clk);
		#1;
		cfg_wr_en = 1'b0;
		cfg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
		@(posedge core_clk);
		#1;
		cfg_rd_en = 1'b1;
		cfg_addr = a;
		@(posedge core_clk);
		#1;
		d = cfg_rdata;
		v = cfg_rd_valid;
		cfg_rd_en = 1'b0;
	endtask
endmodule

// >>> bt1h_bridge_hdr_tb.sv
// Self-checking bench for the bridge header lower register bank.
// Assumes the host model drives the configuration port; other inputs come from here.
`timescale 1ns/1ps
module bt1h_bridge_hdr_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic up = 1'b1;
	logic ce = 1'b1;
	logic wr_en, rd_en, rd_valid, nv_en = 1'b0, perr = 1'b0, pcpl = 1'b0, pwr = 1'b0;
	logic rec, rq = 1'b0, rq_sec = 1'b0, fv, fd, fu;
	logic [7:0] addr, nv_addr = 8'h00, sec_bus, sub_bus;
	logic [3:0] be;
	logic [31:0] wdata, rdata, nv_data = 32'h0000_0000, rq_addr = 32'h0000_0000;
	logic [15:0] bup = 16'h0000, lup = 16'h0000;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;

	always #20 core_clk = ~core_clk;

	bt1h_host_model host (.core_clk(core_clk), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en),
		.cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata),
		.cfg_rd_valid(rd_valid));

	bt1h_bridge_hdr DUT (.core_clk(core_clk), .arst_n(arst_n), .ce(ce),
		.port_is_upstream(up), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en), .cfg_addr(addr),
		.cfg_be(be), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rd_valid(rd_valid),
		.nv_wr_en(nv_en), .nv_addr(nv_addr), .nv_wdata(nv_data), .perr_resp_en(perr),
		.poison_cpl_rx(pcpl), .poison_wr_fwd(pwr), .poison_record(rec),
		.io_base_upper(bup), .io_limit_upper(lup), .io_req_valid(rq),
		.io_req_from_secondary(rq_sec), .io_req_addr(rq_addr), .io_fwd_valid(fv),
		.io_fwd_down(fd), .io_fwd_up(fu), .secondary_bus(sec_bus),
		.subordinate_bus(sub_bus));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// The ceiling is over twenty times the hundred-odd cycles the sequence needs.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	task automatic chk_bit(input string nm, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %b seen %b", nm, exp, got);
			miscompares++;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic v;
		host.rd(a, d, v);
		chk_bit("rd_valid", 1'b1, v);
		chk_word("cfg_rdata", exp, d);
	endtask

	task automatic ioq(input logic sec, input logic [31:0] a, input logic dn, input logic upx);
		@(posedge core_clk);
		#1;
		rq = 1'b1;
		rq_sec = sec;
		rq_addr = a;
		@(posedge core_clk);
		#1;
		rq = 1'b0;
		chk_bit("io_fwd_valid", 1'b1, fv);
		chk_bit("io_fwd_down", dn, fd);
		chk_bit("io_fwd_up", upx, fu);
	endtask

	task automatic poison(input logic cpl);
		@(posedge core_clk);
		#1;
		pcpl = cpl;
		pwr = ~cpl;
		@(posedge core_clk);
		#1;
		pcpl = 1'b0;
		pwr = 1'b0;
		chk_bit("poison_record", 1'b1, rec);
	endtask

	task automatic t_reset();
		rdc(8'h0c, 32'h0001_0000);
		rdc(8'h18, 32'h0000_0000);
		rdc(8'h1c, 32'h0000_01f1);
		rdc(8'h40, 32'h0000_0000);
		ioq(1'b0, 32'h0000_f000, 1'b0, 1'b0);
		ioq(1'b1, 32'h0000_0000, 1'b0, 1'b1);
		$display("test reset done");
	endtask

	task automatic t_misc_bus();
		host.wr(8'h0c, 4'hf, 32'hffff_ffff);
		rdc(8'h0c, 32'h0001_00ff);
		host.wr(8'h18, 4'hf, 32'hffff_ffff);
		host.wr(8'h18, 4'h2, 32'h0000_5a00);
		rdc(8'h18, 32'h00ff_5aff);
		chk_word("secondary_bus", 32'h5a, {24'h0, sec_bus});
		chk_word("subordinate_bus", 32'hff, {24'h0, sub_bus});
		$display("test misc and bus numbers done");
	endtask

	task automatic t_bar();
		host.wr(8'h10, 4'hf, 32'hffff_ffff);
		rdc(8'h10, 32'hfffc_0000);
		host.wr(8'h14, 4'hf, 32'hffff_ffff);
		rdc(8'h14, 32'h0000_0000);
		@(posedge core_clk);
		#1;
		nv_en = 1'b1;
		nv_addr = 8'h10;
		nv_data = 32'h0000_0004;
		@(posedge core_clk);
		#1;
		nv_en = 1'b0;
		rdc(8'h10, 32'h0000_0004);
		host.wr(8'h14, 4'hf, 32'hffff_ffff);
		rdc(8'h14, 32'hffff_ffff);
		host.wr(8'h10, 4'hf, 32'hffff_fff9);
		rdc(8'h10, 32'hfffc_0004);
		$display("test base address done");
	endtask

	task automatic t_io();
		host.wr(8'h1c, 4'h3, 32'h0000_2010);
		rdc(8'h1c, 32'h0000_2111);
		ioq(1'b0, 32'h0000_1000, 1'b1, 1'b0);
		ioq(1'b0, 32'h0000_2fff, 1'b1, 1'b0);
		ioq(1'b0, 32'h0000_3000, 1'b0, 1'b0);
		ioq(1'b1, 32'h0000_0fff, 1'b0, 1'b1);
		ioq(1'b1, 32'h0000_2000, 1'b0, 1'b0);
		bup = 16'h0001;
		lup = 16'h0001;
		ioq(1'b0, 32'h0000_1000, 1'b0, 1'b0);
		ioq(1'b0, 32'h0001_2fff, 1'b1, 1'b0);
		host.wr(8'h1c, 4'h1, 32'h0000_0030);
		ioq(1'b0, 32'h0001_2000, 1'b0, 1'b0);
		ioq(1'b1, 32'h0001_2000, 1'b0, 1'b1);
		host.wr(8'h1c, 4'h1, 32'h0000_0010);
		$display("test io window done");
	endtask

	task automatic t_poison();
		poison(1'b1);
		rdc(8'h1c, 32'h0000_2111);
		perr = 1'b1;
		poison(1'b0);
		rdc(8'h1c, 32'h0100_2111);
		host.wr(8'h1c, 4'h8, 32'h0000_0000);
		rdc(8'h1c, 32'h0100_2111);
		host.wr(8'h1c, 4'h8, 32'hffff_ffff);
		rdc(8'h1c, 32'h0000_2111);
		// A poison event and a clear in the same cycle: the event must not be lost.
		fork
			host.wr(8'h1c, 4'h8, 32'h0100_0000);
			poison(1'b1);
		join
		rdc(8'h1c, 32'h0100_2111);
		host.wr(8'h1c, 4'h8, 32'hffff_ffff);
		rdc(8'h1c, 32'h0000_2111);
		$display("test poison status done");
	endtask

	task automatic t_ce();
		logic [31:0] d;
		logic v;
		// Let the last read answer retire before freezing, or its valid would stay frozen high.
		@(posedge core_clk);
		#1;
		ce = 1'b0;
		host.wr(8'h0c, 4'h1, 32'h0000_0055);
		host.rd(8'h0c, d, v);
		chk_bit("rd_valid", 1'b0, v);
		ce = 1'b1;
		rdc(8'h0c, 32'h0001_00ff);
		$display("test clock enable done");
	endtask

	task automatic t_down();
		up = 1'b0;
		repeat (3) @(posedge core_clk);
		host.wr(8'h10, 4'hf, 32'hffff_ffff);
		rdc(8'h10, 32'h0000_0000);
		rdc(8'h14, 32'h0000_0000);
		$display("test downstream role done");
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_misc_bus();
		t_bar();
		t_io();
		t_poison();
		t_down();
		t_ce();
		end_of_test();
	end
endmodule
